/* File: include/ulf_pkg.sv */
// Purpose: shared constants, field layouts and helpers of the serial channel
// Assumes: one channel, byte-wide register port with a 3-bit address
// Notes: struct field order follows the register bit order, msb first
package ulf_pkg;
  // ==========================================================
  // register map
  localparam int         ADDR_W  = 3;
  localparam int         DATA_W  = 8;
  localparam logic [2:0] A_DATA  = 3'h0;
  localparam logic [2:0] A_IMASK = 3'h1;
  localparam logic [2:0] A_FCTL  = 3'h2;
  localparam logic [2:0] A_LCR   = 3'h3;
  localparam logic [2:0] A_MCR   = 3'h4;
  localparam logic [2:0] A_LSR   = 3'h5;
  localparam logic [2:0] A_MSR   = 3'h6;
  localparam logic [2:0] A_SCR   = 3'h7;
  // ==========================================================
  // field positions
  localparam int FC_EN      = 0;
  localparam int FC_RXRST   = 1;
  localparam int FC_TXRST   = 2;
  localparam int FC_DMA     = 3;
  localparam int FC_TRIG_LO = 6;
  localparam int FC_TRIG_HI = 7;
  localparam int IMASK_W    = 3;
  localparam int IM_RX      = 0;
  localparam int IM_TX      = 1;
  localparam int IM_LINE    = 2;
  // ==========================================================
  // reset values and codes
  localparam logic [7:0]  SCR_RST   = 8'hFF;
  localparam logic [15:0] DIV_RST   = 16'h0001;
  localparam logic [15:0] DIV_MIN   = 16'h0001;
  localparam logic [5:0]  ISR_IDLE  = 6'h01;
  localparam logic [4:0]  SYNC_IDLE = 5'h1F;
  localparam logic [3:0]  WL_BASE   = 4'h5;
  localparam logic [1:0]  WL_MAX    = 2'h3;
  localparam logic [7:0]  MASK8     = 8'hFF;
  // ==========================================================
  // timing in 16x sample ticks, then rx trigger levels in characters
  localparam logic [5:0] T_BIT    = 6'h10;
  localparam logic [5:0] T_MID    = 6'h08;
  localparam logic [5:0] T_STOP15 = 6'h18;
  localparam logic [5:0] T_STOP2  = 6'h20;
  localparam logic [4:0] TRIG_A   = 5'h01;
  localparam logic [4:0] TRIG_B   = 5'h04;
  localparam logic [4:0] TRIG_C   = 5'h08;
  localparam logic [4:0] TRIG_D   = 5'h0E;
  // ==========================================================
  // types
  typedef struct packed {
    logic dlab, brk, stick, even, pen, stop2;
    logic [1:0] wlen;
  } ulf_lcr_s;
  typedef struct packed {logic loop, out2, out1, rts, dtr;} ulf_mcr_s;
  typedef struct packed {logic fifo_err, temt, thre, brk, ferr, perr, ovr, dr;} ulf_lsr_s;
  typedef struct packed {logic brk, ferr, perr; logic [7:0] data;} ulf_rxe_s;
  typedef struct packed {logic wr, rd; logic [ADDR_W-1:0] addr; logic [DATA_W-1:0] wdata;} ulf_req_s;
  // ==========================================================
  // helpers
  function automatic logic [3:0] ulf_nbits(input logic [1:0] wl);
    return WL_BASE + {2'h0, wl};
  endfunction
  function automatic logic ulf_parity(input logic [7:0] d, input ulf_lcr_s c);
    logic [7:0] m;
    m = d & (MASK8 >> (WL_MAX - c.wlen));
    if (c.stick) return !c.even;
    return c.even ? ^m : ~^m;
  endfunction
  function automatic logic [4:0] ulf_trig(input logic [1:0] code);
    unique case (code)
      2'h0: return TRIG_A;
      2'h1: return TRIG_B;
      2'h2: return TRIG_C;
      2'h3: return TRIG_D;
    endcase
  endfunction
endpackage

/* File: rtl/ulf_tx_serial.sv */
// Purpose: transmit serialiser, start, data lsb first, parity, stop
// Assumes: tick is a one-cycle strobe at 16x the bit rate
// Notes: start is taken only while idle
`timescale 1ns/1ps
module ulf_tx_serial (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset,
  // control
  input  wire logic              tick,
  input  wire ulf_pkg::ulf_lcr_s cfg,
  input  wire logic              start,
  input  wire logic [7:0]        data,
  // line
  output logic                   busy,
  output logic                   ser_out
);
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ulf_txph_e;
  typedef struct packed {
    ulf_txph_e ph; logic [5:0] cnt; logic [2:0] idx; logic [7:0] sh; logic par, line;
  } ulf_txst_s;
  ulf_txst_s  st, nxt;
  logic [5:0] limit;
  logic       at_end;
  assign limit = (st.ph != TX_STOP) ? ulf_pkg::T_BIT : !cfg.stop2 ? ulf_pkg::T_BIT :
                 (cfg.wlen == '0) ? ulf_pkg::T_STOP15 : ulf_pkg::T_STOP2;
  assign at_end = tick && (st.cnt == limit - 1'b1);
  assign busy = st.ph != TX_IDLE;
  assign ser_out = st.line;
  always_comb begin
    nxt = st;
    if (tick) nxt.cnt = st.cnt + 1'b1;
    if (at_end) nxt.cnt = '0;
    unique case (st.ph)
      TX_IDLE: if (start) begin
        nxt.ph = TX_START;
        nxt.cnt = '0;
        nxt.sh = data;
        nxt.par = ulf_pkg::ulf_parity(data, cfg);
        nxt.line = 1'b0;
      end
      TX_START: if (at_end) begin
        nxt.ph = TX_DATA;
        nxt.idx = '0;
        nxt.line = st.sh[0];
      end
      TX_DATA: if (at_end) begin
        if ({1'b0, st.idx} == ulf_pkg::ulf_nbits(cfg.wlen) - 4'h1) begin
          nxt.ph = cfg.pen ? TX_PAR : TX_STOP;
          nxt.line = cfg.pen ? st.par : 1'b1;
        end else begin
          nxt.idx = st.idx + 1'b1;
          nxt.sh = st.sh >> 1;
          nxt.line = st.sh[1];
        end
      end
      TX_PAR: if (at_end) begin
        nxt.ph = TX_STOP;
        nxt.line = 1'b1;
      end
      TX_STOP: if (at_end) nxt.ph = TX_IDLE;
      default: nxt.ph = TX_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st <= '0;
      st.line <= 1'b1;
    end else begin
      st <= nxt;
    end
  end
endmodule

/* File: rtl/ulf_rx_serial.sv */
// Purpose: receive deserialiser with mid-bit sampling at 16x
// Assumes: line_in is already synchronised to sys_clk
// Notes: after a low stop bit it waits for mark before rearming
`timescale 1ns/1ps
module ulf_rx_serial (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset,
  // control and line
  input  wire logic              tick,
  input  wire ulf_pkg::ulf_lcr_s cfg,
  input  wire logic              line_in,
  // received character
  output logic                   done,
  output ulf_pkg::ulf_rxe_s      entry
);
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_HOLD} ulf_rxph_e;
  typedef struct packed {
    ulf_rxph_e ph; logic [5:0] cnt; logic [2:0] idx; logic [7:0] sh; logic pbit, done;
    ulf_pkg::ulf_rxe_s ent;
  } ulf_rxst_s;
  ulf_rxst_s st, nxt;
  logic      at_end;
  assign at_end = tick && (st.cnt == ((st.ph == RX_START) ? ulf_pkg::T_MID : ulf_pkg::T_BIT) - 1'b1);
  assign done = st.done;
  assign entry = st.ent;
  always_comb begin
    nxt = st;
    nxt.done = 1'b0;
    if (tick) nxt.cnt = st.cnt + 1'b1;
    if (at_end) nxt.cnt = '0;
    unique case (st.ph)
      RX_IDLE: if (!line_in) begin
        nxt.ph = RX_START;
        nxt.cnt = '0;
      end
      RX_START: if (at_end) begin
        nxt.ph = line_in ? RX_IDLE : RX_DATA;
        nxt.idx = '0;
        nxt.sh = '0;
      end
      RX_DATA: if (at_end) begin
        nxt.sh[st.idx] = line_in;
        nxt.idx = st.idx + 1'b1;
        if ({1'b0, st.idx} == ulf_pkg::ulf_nbits(cfg.wlen) - 4'h1)
          nxt.ph = cfg.pen ? RX_PAR : RX_STOP;
      end
      RX_PAR: if (at_end) begin
        nxt.pbit = line_in;
        nxt.ph = RX_STOP;
      end
      RX_STOP: if (at_end) begin
        nxt.done = 1'b1;
        nxt.ent.data = st.sh;
        nxt.ent.ferr = !line_in;
        nxt.ent.perr = cfg.pen && (st.pbit != ulf_pkg::ulf_parity(st.sh, cfg));
        nxt.ent.brk = !line_in && (st.sh == '0) && !(cfg.pen && st.pbit);
        nxt.ph = line_in ? RX_IDLE : RX_HOLD;
      end
      RX_HOLD: if (line_in) nxt.ph = RX_IDLE;
      default: nxt.ph = RX_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (reset) st <= '0;
    else st <= nxt;
  end
endmodule

/* File: rtl/ulf_uart_channel.sv */
// Purpose: one serial channel with FIFOs, line format, modem outputs and line status
// Assumes: byte register port, read data one cycle after the read strobe
// Notes: divisor counts sys_clk cycles per 16x sample tick
//
// Summary of operation
// - rx FIFO reset clears pointers, self-clears
// - tx FIFO reset clears pointers, self-clears
// - DMA bit changes ready pin behaviour
// - trigger code picks 1,4,8,14 level
// - word length 5 to 8 bits
// - stop bits: one, or 1.5/2
// - parity enable adds and checks parity
// - parity type bit: odd or even
// - forced parity constant, inverse of type
// - break holds transmit line low
// - divisor access bit remaps data addresses
// - terminal-ready pin is inverted control bit
// - request-to-send pin is inverted control bit
// - bit two feeds ring indicator in loopback
// - bit three enables interrupt, drives aux pin
// - loopback bit selects local loopback mode
// - data ready while any character waits
// - full FIFO sets overrun, drops character
// - parity flag belongs to head character
// - framing flag belongs to head character
// - break loads one character, held till mark
// - transmit empty needs holding/FIFO empty and serialiser idle
// - loopback: clear-to-send mirrors request-to-send
`timescale 1ns/1ps
module ulf_uart_channel #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset,
  // register port
  input  wire ulf_pkg::ulf_req_s bus_req,
  output logic [7:0]             rdata,
  // serial line
  output logic                   tx_pin,
  input  wire logic              rx_pin,
  // modem inputs, active low
  input  wire logic              cts_n,
  input  wire logic              dsr_n,
  input  wire logic              ring_indicator_n,
  input  wire logic              cd_n,
  // modem and auxiliary outputs, active low
  output logic                   dtr_n,
  output logic                   rts_n,
  output logic                   aux_out_two_n,
  // interrupt with output enable
  output logic                   int_out,
  output logic                   int_oe,
  // transfer ready pins
  output logic                   tx_ready_n,
  output logic                   rx_ready_n
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  // ==========================================================
  // state
  typedef struct packed {
    ulf_pkg::ulf_lcr_s                  line_format_control;
    ulf_pkg::ulf_mcr_s                  modem_output_control;
    logic [ulf_pkg::IMASK_W-1:0]        imask;
    logic [7:0]                         scr;
    logic [7:0]                         dll;
    logic [7:0]                         divisor_high;
    logic                               fifo_en;
    logic                               dma;
    logic [1:0]                         trig;
    ulf_pkg::ulf_rxe_s [DEPTH-1:0]      rx_mem;
    logic [PW-1:0]                      rx_wp;
    logic [PW-1:0]                      rx_rp;
    logic [CW-1:0]                      rx_cnt;
    logic [CW-1:0]                      err_cnt;
    logic [DEPTH-1:0][7:0]              tx_mem;
    logic [PW-1:0]                      tx_wp;
    logic [PW-1:0]                      tx_rp;
    logic [CW-1:0]                      tx_cnt;
    logic                               tx_go;
    logic [7:0]                         tx_byte;
    logic                               ovr;
    logic                               brk_hold;
    logic [15:0]                        div_cnt;
    logic                               tick;
    logic [4:0]                         s1;
    logic [4:0]                         s2;
    logic [4:0]                         s3;
    logic [4:0]                         filt;
    logic                               tx_pin;
    logic                               dtr_n;
    logic                               rts_n;
    logic                               aux2_n;
    logic                               irq;
    logic                               txr_n;
    logic                               rxr_n;
    logic [7:0]                         rdata;
  } ulf_core_s;

  ulf_core_s          st;
  ulf_core_s          nxt;
  ulf_pkg::ulf_rxe_s  head;
  ulf_pkg::ulf_rxe_s  rx_ent;
  ulf_pkg::ulf_lsr_s  line_status;
  logic [3:0]         msr_stat;
  logic               tx_busy;
  logic               tx_ser;
  logic               rx_done;
  logic               loop_line;
  logic               rx_line;
  logic               rx_full;
  logic               tx_full;
  logic               trig_hit;
  logic               rx_push;
  logic               rx_pop;
  logic               rx_clr;
  logic               tx_push;
  logic               tx_pop;
  logic               tx_clr;

  // ==========================================================
  // helpers
  function automatic logic fifo_full(input logic [CW-1:0] n, input logic en);
    return en ? (n >= CW'(DEPTH)) : (n != '0);
  endfunction

  function automatic logic has_err(input ulf_pkg::ulf_rxe_s e);
    return e.brk | e.ferr | e.perr;
  endfunction

  // ==========================================================
  // serial engines
  ulf_tx_serial u_tx (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tick    (st.tick),
    .cfg     (st.line_format_control),
    .start   (st.tx_go),
    .data    (st.tx_byte),
    .busy    (tx_busy),
    .ser_out (tx_ser)
  );

  ulf_rx_serial u_rx (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tick    (st.tick),
    .cfg     (st.line_format_control),
    .line_in (rx_line),
    .done    (rx_done),
    .entry   (rx_ent)
  );

  // ==========================================================
  // status views
  assign loop_line = st.line_format_control.brk ? 1'b0 : tx_ser;
  assign rx_line   = st.modem_output_control.loop ? loop_line : st.filt[0];
  assign head      = st.rx_mem[st.rx_rp];
  assign rx_full   = fifo_full(st.rx_cnt, st.fifo_en);
  assign tx_full   = fifo_full(st.tx_cnt, st.fifo_en);
  assign trig_hit  = st.fifo_en ? (st.rx_cnt >= CW'(ulf_pkg::ulf_trig(st.trig)))
                                : (st.rx_cnt != '0);

  always_comb begin
    line_status          = '0;
    line_status.dr       = st.rx_cnt != '0;
    line_status.ovr      = st.ovr;
    line_status.perr     = line_status.dr && head.perr;
    line_status.ferr     = line_status.dr && head.ferr;
    line_status.brk      = (line_status.dr && head.brk) || st.brk_hold;
    line_status.thre     = st.tx_cnt == '0;
    line_status.temt     = line_status.thre && !tx_busy && !st.tx_go;
    line_status.fifo_err = st.err_cnt != '0;
  end

  // loopback feeds the status bits from the control bits
  assign msr_stat = st.modem_output_control.loop ? {st.modem_output_control.out2, st.modem_output_control.out1, st.modem_output_control.dtr, st.modem_output_control.rts}
                                : ~st.filt[4:1];

  // ==========================================================
  // next state
  always_comb begin
    nxt       = st;
    nxt.rdata = '0;
    nxt.tx_go = 1'b0;
    nxt.tick  = 1'b0;
    rx_pop    = 1'b0;
    rx_clr    = 1'b0;
    tx_push   = 1'b0;
    tx_pop    = 1'b0;
    tx_clr    = 1'b0;

    // 16x sample tick from the divisor
    if (st.div_cnt <= ulf_pkg::DIV_MIN) begin
      nxt.tick = 1'b1;
      nxt.div_cnt = {st.divisor_high, st.dll};
    end else begin
      nxt.div_cnt = st.div_cnt - ulf_pkg::DIV_MIN;
    end

    // three-stage input synchronisers, second and third must agree
    nxt.s1 = {cd_n, ring_indicator_n, dsr_n, cts_n, rx_pin};
    nxt.s2 = st.s1;
    nxt.s3 = st.s2;
    for (int i = 0; i < 5; i++) begin
      if (st.s2[i] == st.s3[i]) nxt.filt[i] = st.s3[i];
    end

    // register reads
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        ulf_pkg::A_DATA: begin
          if (st.line_format_control.dlab) begin
            nxt.rdata = st.dll;
          end else begin
            nxt.rdata = head.data;
            rx_pop = line_status.dr;
          end
        end
        ulf_pkg::A_IMASK: nxt.rdata = st.line_format_control.dlab ? st.divisor_high : 8'(st.imask);
        ulf_pkg::A_FCTL:  nxt.rdata = {{2{st.fifo_en}}, ulf_pkg::ISR_IDLE};
        ulf_pkg::A_LCR:   nxt.rdata = st.line_format_control;
        ulf_pkg::A_MCR:   nxt.rdata = 8'(st.modem_output_control);
        ulf_pkg::A_LSR: begin
          nxt.rdata = line_status;
          nxt.ovr = 1'b0;
        end
        ulf_pkg::A_MSR:   nxt.rdata = {msr_stat, 4'h0};
        ulf_pkg::A_SCR:   nxt.rdata = st.scr;
      endcase
    end

    // register writes
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        ulf_pkg::A_DATA: begin
          if (st.line_format_control.dlab) nxt.dll = bus_req.wdata;
          else tx_push = !tx_full;
        end
        ulf_pkg::A_IMASK: begin
          if (st.line_format_control.dlab) nxt.divisor_high = bus_req.wdata;
          else nxt.imask = bus_req.wdata[ulf_pkg::IMASK_W-1:0];
        end
        ulf_pkg::A_FCTL: begin
          nxt.fifo_en = bus_req.wdata[ulf_pkg::FC_EN];
          // other bits only land while the enable is written set
          if (bus_req.wdata[ulf_pkg::FC_EN]) begin
            nxt.dma = bus_req.wdata[ulf_pkg::FC_DMA];
            nxt.trig = bus_req.wdata[ulf_pkg::FC_TRIG_HI:ulf_pkg::FC_TRIG_LO];
            rx_clr = bus_req.wdata[ulf_pkg::FC_RXRST];
            tx_clr = bus_req.wdata[ulf_pkg::FC_TXRST];
          end
          // a change of FIFO mode empties both queues
          if (bus_req.wdata[ulf_pkg::FC_EN] != st.fifo_en) begin
            rx_clr = 1'b1;
            tx_clr = 1'b1;
          end
        end
        ulf_pkg::A_LCR: nxt.line_format_control = bus_req.wdata;
        ulf_pkg::A_MCR: nxt.modem_output_control = bus_req.wdata[4:0];
        ulf_pkg::A_SCR: nxt.scr = bus_req.wdata;
        default: ;
      endcase
    end

    // receive side: push, overrun, break hold
    rx_push = rx_done && !rx_full;
    if (rx_done && rx_full) nxt.ovr = 1'b1;
    if (rx_line) nxt.brk_hold = 1'b0;
    if (rx_push && rx_ent.brk) nxt.brk_hold = 1'b1;
    if (rx_push) begin
      nxt.rx_mem[st.rx_wp] = rx_ent;
      nxt.rx_wp = st.rx_wp + 1'b1;
    end
    if (rx_pop) nxt.rx_rp = st.rx_rp + 1'b1;
    nxt.rx_cnt = st.rx_cnt + CW'(rx_push) - CW'(rx_pop);
    nxt.err_cnt = st.err_cnt + CW'(rx_push && has_err(rx_ent)) - CW'(rx_pop && has_err(head));
    // pointers only, the deserialiser keeps running
    if (rx_clr) begin
      nxt.rx_wp = '0;
      nxt.rx_rp = '0;
      nxt.rx_cnt = '0;
      nxt.err_cnt = '0;
    end

    // transmit side: hand the next byte to the serialiser
    tx_pop = !tx_busy && !st.tx_go && !line_status.thre && !tx_clr;
    if (tx_pop) begin
      nxt.tx_go = 1'b1;
      nxt.tx_byte = st.tx_mem[st.tx_rp];
      nxt.tx_rp = st.tx_rp + 1'b1;
    end
    if (tx_push) begin
      nxt.tx_mem[st.tx_wp] = bus_req.wdata;
      nxt.tx_wp = st.tx_wp + 1'b1;
    end
    nxt.tx_cnt = st.tx_cnt + CW'(tx_push) - CW'(tx_pop);
    // the byte already in the serialiser is left alone
    if (tx_clr) begin
      nxt.tx_wp = '0;
      nxt.tx_rp = '0;
      nxt.tx_cnt = '0;
    end

    // pins
    nxt.tx_pin = st.modem_output_control.loop ? 1'b1 : loop_line;
    nxt.dtr_n = st.modem_output_control.loop || !st.modem_output_control.dtr;
    nxt.rts_n = st.modem_output_control.loop || !st.modem_output_control.rts;
    // aux pin moves on the same edge as the interrupt enable
    nxt.aux2_n = nxt.modem_output_control.loop || !nxt.modem_output_control.out2;
    nxt.irq = (st.imask[ulf_pkg::IM_RX] && trig_hit)
           || (st.imask[ulf_pkg::IM_TX] && line_status.thre)
           || (st.imask[ulf_pkg::IM_LINE] && (line_status.ovr || line_status.perr || line_status.ferr || line_status.brk));
    nxt.txr_n = st.dma ? tx_full : !line_status.thre;
    nxt.rxr_n = st.dma ? !trig_hit : !line_status.dr;
  end

  // ==========================================================
  // state register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st <= '0;
      st.scr <= ulf_pkg::SCR_RST;
      {st.divisor_high, st.dll} <= ulf_pkg::DIV_RST;
      st.s1 <= ulf_pkg::SYNC_IDLE;
      st.s2 <= ulf_pkg::SYNC_IDLE;
      st.s3 <= ulf_pkg::SYNC_IDLE;
      st.filt <= ulf_pkg::SYNC_IDLE;
      st.tx_pin <= 1'b1;
      st.dtr_n <= 1'b1;
      st.rts_n <= 1'b1;
      st.aux2_n <= 1'b1;
      st.rxr_n <= 1'b1;
    end else begin
      st <= nxt;
    end
  end

  // ==========================================================
  // outputs
  assign rdata         = st.rdata;
  assign tx_pin        = st.tx_pin;
  assign dtr_n         = st.dtr_n;
  assign rts_n         = st.rts_n;
  assign aux_out_two_n = st.aux2_n;
  assign int_out       = st.irq;
  assign int_oe        = st.modem_output_control.out2;
  assign tx_ready_n    = st.txr_n;
  assign rx_ready_n    = st.rxr_n;
endmodule

/* File: verif/ulf_peer.sv */
// Purpose: remote serial peer on the channel's line
// Assumes: divisor 1, so 16 clocks per bit
// Notes: frames are given lsb first, start and stop included
`timescale 1ns/1ps
module ulf_peer (
  // line
  input  wire logic sys_clk,
  input  wire logic line_in,
  output logic      line_out
);
  // ==========
  // send and take frames
  initial line_out = 1'b1;
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      line_out <= f[i];
      repeat (16) @(posedge sys_clk);
    end
    line_out <= 1'b1;
  endtask
  task automatic take(input int n, output logic [11:0] f);
    int k;
    f = 'x;
    for (k = 0; k < 4000 && line_in; k++) @(posedge sys_clk);
    if (k == 4000) return;
    f = '0;
    repeat (8) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      f[i] = line_in;
      repeat (16) @(posedge sys_clk);
    end
  endtask
endmodule

/* File: verif/ulf_uart_channel_sva.sv */
// Purpose: port assertions of the serial channel
// Assumes: loopback is off while break is set
// Notes: register pins are settled two edges after a write
`timescale 1ns/1ps
module ulf_uart_channel_sva (
  // clock, reset and bus
  input wire logic              sys_clk,
  input wire logic              reset,
  input wire ulf_pkg::ulf_req_s bus_req,
  // observed outputs
  input wire logic [7:0]        rdata,
  input wire logic              tx_pin,
  input wire logic              dtr_n,
  input wire logic              rts_n,
  input wire logic              aux_out_two_n,
  input wire logic              int_oe,
  input wire logic              tx_ready_n,
  input wire logic              rx_ready_n
);
  // ==========
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic mw, lw;
  assign mw = bus_req.wr && bus_req.addr == ulf_pkg::A_MCR;
  assign lw = bus_req.wr && bus_req.addr == ulf_pkg::A_LCR;
  reset_pins_a: assert property ($fell(reset) |-> tx_pin && dtr_n && rts_n
    && aux_out_two_n && rx_ready_n && !tx_ready_n) else $error("pin wrong after reset");
  rdata_idle_a: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  aux_high_a: assert property (!int_oe |-> aux_out_two_n)
    else $error("aux pin low with interrupt off");
  dtr_pin_a: assert property (mw && !bus_req.wdata[4] |->
    ##2 dtr_n == !$past(bus_req.wdata[0], 2)) else $error("terminal ready pin wrong");
  rts_pin_a: assert property (mw && !bus_req.wdata[4] |->
    ##2 rts_n == !$past(bus_req.wdata[1], 2)) else $error("send request pin wrong");
  int_enable_a: assert property (mw |-> ##2 int_oe == $past(bus_req.wdata[3], 2))
    else $error("interrupt enable wrong");
  loop_idle_a: assert property (mw && bus_req.wdata[4] |->
    ##2 (tx_pin && dtr_n && rts_n)[*4]) else $error("pins not idle in loopback");
  break_low_a: assert property (lw && bus_req.wdata[6] |-> ##2 (!tx_pin)[*4])
    else $error("break not driven");
endmodule
bind ulf_uart_channel ulf_uart_channel_sva u_sva (.sys_clk, .reset, .bus_req, .rdata, .tx_pin,
  .dtr_n, .rts_n, .aux_out_two_n, .int_oe, .tx_ready_n, .rx_ready_n);

/* File: verif/tb.sv */
// Purpose: directed bench of the serial channel
// Assumes: divisor 1, so 16 clocks per bit
// Notes: the peer drives rx_pin and listens on tx_pin
`timescale 1ns/1ps
module tb;
  // ==========
  // clock, reset and wiring
  logic              sys_clk = 1'b0;
  logic              reset = 1'b1;
  ulf_pkg::ulf_req_s bus_req = '0;
  logic [7:0]        rdata;
  logic [3:0]        mdm_n = 4'hF;
  logic              tx_pin, rx_pin, dtr_n, rts_n, aux_out_two_n, int_out, int_oe;
  logic              tx_ready_n, rx_ready_n;
  int                failures = 0;
  int                comparisons = 0;
  always #25 sys_clk = ~sys_clk;
  ulf_uart_channel dut (.sys_clk, .reset, .bus_req, .rdata, .tx_pin, .rx_pin, .cts_n(mdm_n[0]),
    .dsr_n(mdm_n[1]), .ring_indicator_n(mdm_n[2]), .cd_n(mdm_n[3]), .dtr_n, .rts_n,
    .aux_out_two_n, .int_out, .int_oe, .tx_ready_n, .rx_ready_n);
  ulf_peer peer (.sys_clk, .line_in(tx_pin), .line_out(rx_pin));
  // ==========
  // shared tasks
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk) bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk) bus_req <= '0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge sys_clk) bus_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk) bus_req <= '0;
    #1 chk(rdata & m, e);
  endtask
  task automatic summarize;
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_reset;
    rd(ulf_pkg::A_LSR, 8'h60);
    rd(ulf_pkg::A_LCR, 8'h00);
    rd(ulf_pkg::A_MCR, 8'h00);
  endtask
  task automatic t_tx;
    logic [31:0] tv [5] = '{32'h03A5A34A, 32'h00FF707E, 32'h1B03B406, 32'h0B03B606,
                            32'h3B01B402};
    logic [11:0] f;
    for (int i = 0; i < 5; i++) begin
      wr(ulf_pkg::A_LCR, tv[i][31:24]);
      wr(ulf_pkg::A_DATA, tv[i][23:16]);
      peer.take(int'(tv[i][15:12]), f);
      chk(f, tv[i][11:0]);
      if ($isunknown(f)) summarize();
      cyc(24);
      rd(ulf_pkg::A_LSR, 8'h60);
    end
    wr(ulf_pkg::A_LCR, 8'h07);
    wr(ulf_pkg::A_DATA, 8'hFF);
    peer.take(10, f);
    rd(ulf_pkg::A_LSR, 8'h20);
  endtask
  task automatic t_brk;
    wr(ulf_pkg::A_LCR, 8'h43);
    cyc(4);
    chk(tx_pin, 1'b0);
    wr(ulf_pkg::A_LCR, 8'h03);
    cyc(2);
    chk(tx_pin, 1'b1);
  endtask
  task automatic t_rxfifo;
    wr(ulf_pkg::A_FCTL, 8'h49);
    for (int i = 0; i < 17; i++) begin
      peer.send({2'b11, i[7:0], 1'b0}, 10);
      cyc(4);
      if (i == 2 || i == 3) chk(rx_ready_n, i == 2);
    end
    rd(ulf_pkg::A_LSR, 8'h63);
    rd(ulf_pkg::A_DATA, 8'h00);
    wr(ulf_pkg::A_FCTL, 8'h4B);
    rd(ulf_pkg::A_LSR, 8'h60);
    repeat (3) wr(ulf_pkg::A_DATA, 8'h55);
    wr(ulf_pkg::A_FCTL, 8'h4D);
    rd(ulf_pkg::A_LSR, 8'h20);
  endtask
  task automatic t_rxerr;
    logic [39:0] ev [7] = '{40'h0BB4020101, 40'h0BB6020501, 40'h1BB6020101, 40'h2BB4020501,
                            40'h3BB4020101, 40'h03A0020901, 40'h00706A0115};
    for (int i = 0; i < 7; i++) begin
      wr(ulf_pkg::A_LCR, ev[i][39:32]);
      peer.send(ev[i][27:16], int'(ev[i][31:28]));
      cyc(4);
      rd(ulf_pkg::A_LSR, ev[i][15:8], 8'h0D);
      rd(ulf_pkg::A_DATA, ev[i][7:0]);
    end
  endtask
  task automatic t_rxbrk;
    wr(ulf_pkg::A_LCR, 8'h03);
    peer.send(12'h000, 12);
    cyc(4);
    rd(ulf_pkg::A_LSR, 8'h19, 8'h1F);
    rd(ulf_pkg::A_DATA, 8'h00);
    rd(ulf_pkg::A_LSR, 8'h00, 8'h1F);
  endtask
  task automatic t_loop;
    logic lo;
    wr(ulf_pkg::A_MCR, 8'h16);
    rd(ulf_pkg::A_MSR, 8'h50, 8'hF0);
    wr(ulf_pkg::A_DATA, 8'h5A);
    lo = 1'b1;
    repeat (200) @(posedge sys_clk) lo &= tx_pin;
    chk(lo, 1'b1);
    rd(ulf_pkg::A_DATA, 8'h5A);
    wr(ulf_pkg::A_MCR, 8'h0B);
    cyc(2);
    chk({dtr_n, rts_n, aux_out_two_n, int_oe}, 4'h1);
    wr(ulf_pkg::A_IMASK, 8'h02);
    cyc(2);
    chk(int_out, 1'b1);
  endtask
  task automatic t_dlab;
    wr(ulf_pkg::A_LCR, 8'h83);
    wr(ulf_pkg::A_IMASK, 8'h00);
    wr(ulf_pkg::A_DATA, 8'h01);
    rd(ulf_pkg::A_DATA, 8'h01);
    wr(ulf_pkg::A_LCR, 8'h03);
    rd(ulf_pkg::A_LCR, 8'h03);
  endtask
  // ==========
  // main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_tx();
    t_brk();
    t_rxfifo();
    t_rxerr();
    t_rxbrk();
    t_loop();
    t_dlab();
    summarize();
  end
endmodule
